// ### rtl/conditional_skip_exec.v
// What this block does
// RULE1: The memory-increment skip adds one to the addressed byte and writes it back there.
// RULE2: A zero increment result skips the next instruction so it never executes.
// RULE3: A nonzero result continues with the next instruction with no extra cycle.
// RULE4: A taken skip inserts a dummy cycle while the next instruction is fetched and discarded.
// RULE5: A conditional skip that is taken takes three instruction cycles in total.
// RULE6: The accumulator variant puts the byte plus one into the accumulator, skipping on zero.
// RULE7: The accumulator variant leaves the addressed memory byte unchanged.
// RULE8: The bit-test skip skips the next instruction when the selected bit of the byte is one.
// RULE9: None of these instructions changes any status flag.
`timescale 1ns/1ps
`include "skip_exec_regs.vh"

module conditional_skip_exec (
  input  wire                     clk_i,
  input  wire                     reset_n_i,
  // Instruction issue from decode
  input  wire                     instr_valid_i,
  input  wire [`SKIP_OP_W-1:0]    instr_op_i,
  input  wire [`SKIP_ADDR_W-1:0]  instr_addr_i,
  input  wire [`SKIP_BIT_W-1:0]   instr_bit_i,
  output reg                      ready_o,
  // Data memory port, read data one cycle after the read strobe
  output reg                      mem_rd_en_o,
  output reg                      mem_wr_en_o,
  output reg  [`SKIP_ADDR_W-1:0]  mem_addr_o,
  output reg  [`SKIP_DATA_W-1:0]  mem_wdata_o,
  input  wire [`SKIP_DATA_W-1:0]  mem_rdata_i,
  // Accumulator write port
  output reg                      acc_wr_en_o,
  output reg  [`SKIP_DATA_W-1:0]  acc_wdata_o,
  // Fetch pipeline control
  output reg                      skip_o,
  output reg                      dummy_cycle_o,
  output reg                      done_o,
  // Status flag write strobe
  output reg                      flag_wr_en_o
);

  // Sequencer state
  reg [`ST_W-1:0]         state_q;
  reg [`ST_W-1:0]         state_d;

  // Latched instruction fields
  reg [`SKIP_OP_W-1:0]    op_q;
  reg [`SKIP_OP_W-1:0]    op_d;
  reg [`SKIP_BIT_W-1:0]   bit_q;
  reg [`SKIP_BIT_W-1:0]   bit_d;
  reg [`SKIP_ADDR_W-1:0]  addr_d;

  // Registered output next values
  reg                     ready_d;
  reg                     mem_rd_en_d;
  reg                     mem_wr_en_d;
  reg [`SKIP_DATA_W-1:0]  mem_wdata_d;
  reg                     acc_wr_en_d;
  reg [`SKIP_DATA_W-1:0]  acc_wdata_d;
  reg                     skip_d;
  reg                     dummy_cycle_d;
  reg                     done_d;

  // Evaluator results
  wire [`SKIP_DATA_W-1:0] result;
  wire                    skip_hit;

  // Increment and skip decision on the returned byte
  skip_eval #(
    .WIDTH      (`SKIP_DATA_W)
  ) u_skip_eval (
    .operand_i  (mem_rdata_i),
    .op_i       (op_q),
    .bit_sel_i  (bit_q),
    .result_o   (result),
    .skip_hit_o (skip_hit)
  );

  // Next state and output decode
  always @*
  begin
    state_d       = state_q;
    op_d          = op_q;
    bit_d         = bit_q;
    addr_d        = mem_addr_o;
    ready_d       = 1'b0;
    mem_rd_en_d   = 1'b0;
    mem_wr_en_d   = 1'b0;
    mem_wdata_d   = mem_wdata_o;
    acc_wr_en_d   = 1'b0;
    acc_wdata_d   = acc_wdata_o;
    skip_d        = 1'b0;
    dummy_cycle_d = 1'b0;
    done_d        = 1'b0;
    case (state_q)
      `ST_IDLE:
      begin
        ready_d = 1'b1;
        if (instr_valid_i)
        begin
          // First instruction cycle: read the operand byte
          state_d     = `ST_READ;
          op_d        = instr_op_i;
          bit_d       = instr_bit_i;
          addr_d      = instr_addr_i;
          mem_rd_en_d = 1'b1;
          ready_d     = 1'b0;
        end
      end
      `ST_READ:
      begin
        // Read data arrives during the next cycle
        state_d = `ST_EXEC;
      end
      `ST_EXEC:
      begin
        // Second instruction cycle: increment ops write their result, all ops decide
        case (op_q)
          `OP_INC_MEM_SKIP_ZERO:
          begin
            mem_wr_en_d = 1'b1;                 // [RULE1]
            mem_wdata_d = result;               // [RULE1]
          end
          `OP_INC_TO_ACC_SKIP_ZERO:
          begin
            acc_wr_en_d = 1'b1;                 // [RULE6]
            acc_wdata_d = result;               // [RULE6]
            mem_wr_en_d = 1'b0;                 // [RULE7]
          end
          default:
            mem_wr_en_d = 1'b0;
        endcase
        if (skip_hit)
        begin
          // Taken skip: hold one dummy cycle, next fetch discarded
          state_d       = `ST_DUMMY;            // [RULE2] [RULE8]
          skip_d        = 1'b1;                 // [RULE4]
          dummy_cycle_d = 1'b1;                 // [RULE4] [RULE5]
        end
        else
        begin
          // Fall through with no extra cycle
          state_d = `ST_IDLE;                   // [RULE3]
          done_d  = 1'b1;                       // [RULE3]
          ready_d = 1'b1;
        end
      end
      `ST_DUMMY:
      begin
        // Third instruction cycle ends the taken skip
        state_d = `ST_IDLE;                     // [RULE5]
        done_d  = 1'b1;                         // [RULE5]
        ready_d = 1'b1;
      end
      default:
      begin
        state_d = `ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // State and instruction field registers
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= `ST_IDLE;
      op_q    <= `OP_INC_MEM_SKIP_ZERO;
      bit_q   <= {`SKIP_BIT_W{`RST_BIT}};
    end
    else
    begin
      state_q <= state_d;
      op_q    <= op_d;
      bit_q   <= bit_d;
    end
  end

  // Memory and accumulator port registers
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mem_rd_en_o <= 1'b0;
      mem_wr_en_o <= 1'b0;
      mem_addr_o  <= `RST_ADDR;
      mem_wdata_o <= `RST_DATA;
      acc_wr_en_o <= 1'b0;
      acc_wdata_o <= `RST_DATA;
    end
    else
    begin
      mem_rd_en_o <= mem_rd_en_d;
      mem_wr_en_o <= mem_wr_en_d;
      mem_addr_o  <= addr_d;
      mem_wdata_o <= mem_wdata_d;
      acc_wr_en_o <= acc_wr_en_d;
      acc_wdata_o <= acc_wdata_d;
    end
  end

  // Pipeline control registers
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ready_o       <= 1'b0;
      skip_o        <= 1'b0;
      dummy_cycle_o <= 1'b0;
      done_o        <= 1'b0;
      flag_wr_en_o  <= 1'b0;
    end
    else
    begin
      ready_o       <= ready_d;
      skip_o        <= skip_d;
      dummy_cycle_o <= dummy_cycle_d;
      done_o        <= done_d;
      flag_wr_en_o  <= 1'b0;                    // [RULE9]
    end
  end

endmodule

// ### rtl/skip_eval.v
`timescale 1ns/1ps
`include "skip_exec_regs.vh"

// Result and skip decision for one operand byte
module skip_eval #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0]      operand_i,
  input  wire [`SKIP_OP_W-1:0] op_i,
  input  wire [`SKIP_BIT_W-1:0] bit_sel_i,
  output reg  [WIDTH-1:0]      result_o,
  output reg                   skip_hit_o
);

  // Increment, zero test and bit test
  always @*
  begin
    result_o   = operand_i + `SKIP_INC_STEP;   // [RULE1] [RULE6]
    skip_hit_o = 1'b0;
    case (op_i)
      `OP_INC_MEM_SKIP_ZERO,
      `OP_INC_TO_ACC_SKIP_ZERO:
        skip_hit_o = (result_o == `SKIP_ZERO); // [RULE2] [RULE6]
      `OP_BIT_SET_SKIP:
      begin
        result_o   = operand_i;
        skip_hit_o = operand_i[bit_sel_i];     // [RULE8]
      end
      default:
        skip_hit_o = 1'b0;
    endcase
  end

endmodule

// ### rtl/skip_exec_regs.vh
`ifndef SKIP_EXEC_REGS_VH
`define SKIP_EXEC_REGS_VH

// Data path widths
`define SKIP_DATA_W        8
`define SKIP_ADDR_W        8
`define SKIP_BIT_W         3
`define SKIP_OP_W          2

// Operation select codes
`define OP_INC_MEM_SKIP_ZERO    2'h0
`define OP_INC_TO_ACC_SKIP_ZERO 2'h1
`define OP_BIT_SET_SKIP         2'h2

// One-hot sequencer states
`define ST_W               4
`define ST_IDLE            4'h1
`define ST_READ            4'h2
`define ST_EXEC            4'h4
`define ST_DUMMY           4'h8

// Increment step and zero value
`define SKIP_INC_STEP      8'h01
`define SKIP_ZERO          8'h00

// Reset values
`define RST_DATA           8'h00
`define RST_ADDR           8'h00
`define RST_BIT            1'b0

`endif

// ### sim/conditional_skip_exec_tb.sv
`timescale 1ns/1ps
module conditional_skip_exec_tb;
  reg        clk_i = 1'b0;
  reg        reset_n_i = 1'b0;
  reg        instr_valid_i = 1'b0;
  reg  [1:0] instr_op_i = 2'h0;
  reg  [7:0] instr_addr_i = 8'h00;
  reg  [2:0] instr_bit_i = 3'h0;
  reg  [7:0] mem_rdata_i = 8'h00;
  wire       ready_o, mem_rd_en_o, mem_wr_en_o, acc_wr_en_o;
  wire       skip_o, dummy_cycle_o, done_o, flag_wr_en_o;
  wire [7:0] mem_addr_o, mem_wdata_o, acc_wdata_o;
  reg  [7:0] mem [0:255];
  reg  [7:0] acc;
  integer    err_count = 0, n_compared = 0, done_at, skip_at, wr_n;
  always #5 clk_i = ~clk_i;
  conditional_skip_exec conditional_skip_exec_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .instr_addr_i(instr_addr_i),
    .instr_bit_i(instr_bit_i), .ready_o(ready_o), .mem_rd_en_o(mem_rd_en_o),
    .mem_wr_en_o(mem_wr_en_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .acc_wr_en_o(acc_wr_en_o), .acc_wdata_o(acc_wdata_o),
    .skip_o(skip_o), .dummy_cycle_o(dummy_cycle_o), .done_o(done_o),
    .flag_wr_en_o(flag_wr_en_o));
  // Data memory and accumulator; read bus toggles when idle
  always @(posedge clk_i)
  begin
    mem_rdata_i <= mem_rd_en_o ? mem[mem_addr_o] : ~mem_rdata_i;
    if (mem_wr_en_o)
      mem[mem_addr_o] <= mem_wdata_o;
    if (acc_wr_en_o)
      acc <= acc_wdata_o;
  end
  task check(input ok, input [8*16-1:0] msg);
  begin
    n_compared = n_compared + 1;
    if (!ok)
    begin
      err_count = err_count + 1;
      $display("mismatch %0t %0s", $time, msg);
    end
  end
  endtask
  // Issue one instruction, log the done and skip cycles and sum the write strobes weighted 1 memory, 2 accumulator, 4 flags
  task issue(input [1:0] op, input [7:0] a, input [2:0] b);
    integer k;
  begin
    done_at = 0;
    skip_at = 0;
    wr_n = 0;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= op;
    instr_addr_i <= a;
    instr_bit_i <= b;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    for (k = 1; k < 8; k = k + 1)
    begin
      @(negedge clk_i);
      if (done_o === 1'b1 && done_at == 0)
        done_at = k;
      if (skip_o === 1'b1 && dummy_cycle_o === 1'b1)
        skip_at = k;
      wr_n = wr_n + (mem_wr_en_o === 1'b1) + 2 * (acc_wr_en_o === 1'b1)
        + 4 * (flag_wr_en_o !== 1'b0);
    end
  end
  endtask
  task expect_op(input sk, input [2:0] wr);
  begin
    check(done_at == (sk ? 4 : 3), "done cycle");
    check(skip_at == (sk ? 3 : 0), "skip pulse");
    check(wr_n == wr, "strobes");
  end
  endtask
  task t_inc_mem;
  begin
    mem[8'h10] = 8'h41;
    issue(2'h0, 8'h10, 3'h0);
    expect_op(1'b0, 3'h1);
    check(mem[8'h10] === 8'h42, "mem inc");
    mem[8'hFF] = 8'hFF;
    issue(2'h0, 8'hFF, 3'h0);
    expect_op(1'b1, 3'h1);
    check(mem[8'hFF] === 8'h00, "mem wrap");
  end
  endtask
  task t_inc_acc;
  begin
    mem[8'h20] = 8'hFF;
    issue(2'h1, 8'h20, 3'h0);
    expect_op(1'b1, 3'h2);
    check(acc === 8'h00 && mem[8'h20] === 8'hFF, "acc wrap");
    mem[8'h21] = 8'h7F;
    issue(2'h1, 8'h21, 3'h0);
    expect_op(1'b0, 3'h2);
    check(acc === 8'h80 && mem[8'h21] === 8'h7F, "acc inc");
  end
  endtask
  task t_bit;
    integer i;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      mem[8'h30] = 8'h01 << i;
      issue(2'h2, 8'h30, i[2:0]);
      expect_op(1'b1, 3'h0);
      mem[8'h30] = ~(8'h01 << i);
      issue(2'h2, 8'h30, i[2:0]);
      expect_op(1'b0, 3'h0);
    end
    // Spare op code: no write and no skip
    issue(2'h3, 8'h30, 3'h0);
    expect_op(1'b0, 3'h0);
  end
  endtask
  task final_report;
  begin
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_inc_mem;
    t_inc_acc;
    t_bit;
    final_report;
  end
  // Watchdog
  initial
  begin
    #20000;
    err_count = err_count + 1;
    final_report;
  end
endmodule

// ### sim/skip_exec_sva.sv
`timescale 1ns/1ps
module skip_exec_sva (
  input wire       clk_i,
  input wire       reset_n_i,
  input wire       instr_valid_i,
  input wire [7:0] instr_addr_i,
  input wire       ready_o,
  input wire       mem_rd_en_o,
  input wire       mem_wr_en_o,
  input wire [7:0] mem_addr_o,
  input wire [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i,
  input wire       acc_wr_en_o,
  input wire [7:0] acc_wdata_o,
  input wire       skip_o,
  input wire       dummy_cycle_o,
  input wire       done_o,
  input wire       flag_wr_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Issue taken at this edge
  wire take = instr_valid_i && ready_o;
  // Plain and skipping endings
  sequence s_plain; done_o && !skip_o; endsequence
  sequence s_skip; skip_o && dummy_cycle_o ##1 done_o; endsequence
  rd_strobe_a: assert property (take |-> ##1 mem_rd_en_o && mem_addr_o == $past(instr_addr_i))
    else $error("bad read");
  wr_value_a: assert property (mem_wr_en_o |-> mem_wdata_o == $past(mem_rdata_i) + 8'h01)
    else $error("bad write");
  acc_value_a: assert property (acc_wr_en_o |-> acc_wdata_o == $past(mem_rdata_i) + 8'h01)
    else $error("bad acc");
  acc_only_a: assert property (acc_wr_en_o |-> !mem_wr_en_o)
    else $error("acc op wrote memory");
  zero_skip_a: assert property ((mem_wr_en_o && mem_wdata_o == 8'h00)
    || (acc_wr_en_o && acc_wdata_o == 8'h00) |-> s_skip)
    else $error("zero not skipped");
  nz_plain_a: assert property ((mem_wr_en_o && mem_wdata_o != 8'h00)
    || (acc_wr_en_o && acc_wdata_o != 8'h00) |-> s_plain)
    else $error("nonzero skipped");
  dummy_end_a: assert property (dummy_cycle_o |-> skip_o ##1 done_o && ready_o)
    else $error("bad dummy");
  cycle_count_a: assert property (take |-> ##3 (s_plain or s_skip))
    else $error("bad length");
  no_flags_a: assert property (!flag_wr_en_o)
    else $error("flag written");
endmodule
bind conditional_skip_exec skip_exec_sva skip_exec_sva_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .instr_valid_i(instr_valid_i), .instr_addr_i(instr_addr_i), .ready_o(ready_o),
  .mem_rd_en_o(mem_rd_en_o), .mem_wr_en_o(mem_wr_en_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .acc_wr_en_o(acc_wr_en_o),
  .acc_wdata_o(acc_wdata_o), .skip_o(skip_o), .dummy_cycle_o(dummy_cycle_o),
  .done_o(done_o), .flag_wr_en_o(flag_wr_en_o));
